/* include/abm_map.svh */
/*
  Constants of the accumulator ALU and bit manipulation datapath.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef ABM_MAP_SVH
`define ABM_MAP_SVH
`define ABM_ACC_W      36
`define ABM_LOW_W      32
`define ABM_IMM_W      16
`define ABM_GUARD_W    4
`define ABM_HALF_LO    16
`define ABM_MOV_LO     31
`define ABM_AUX_N      4
`define ABM_ALT_N      2
`define ABM_FLD_W_LSB  8
`define ABM_BYTE_W     8
`define ABM_GUARD_POS  4
`define ABM_LONG_CYC   2
`define ABM_ACC_RST    36'h0_0000_0000
`define ABM_AUX_RST    16'h0000
`endif

/* include/abm_pkg.sv */
/*
  Types of the accumulator ALU and bit manipulation datapath.
  Assumes abm_map.svh is compiled alongside.
*/
package abm_pkg;

  typedef enum logic [3:0] {
    ABM_OP_ADD  = 4'h0,
    ABM_OP_SUB  = 4'h1,
    ABM_OP_AND  = 4'h2,
    ABM_OP_OR   = 4'h3,
    ABM_OP_XOR  = 4'h4,
    ABM_OP_ASR  = 4'h5,
    ABM_OP_LSR  = 4'h6,
    ABM_OP_ASL  = 4'h7,
    ABM_OP_EXP  = 4'h8,
    ABM_OP_NORM = 4'h9,
    ABM_OP_EXTS = 4'hA,
    ABM_OP_EXTZ = 4'hB,
    ABM_OP_INS  = 4'hC,
    ABM_OP_SHUF = 4'hD
  } abm_op_t;

  typedef enum logic [2:0] {
    ABM_OPB_ACC    = 3'h0,
    ABM_OPB_PROD   = 3'h1,
    ABM_OPB_IMM_HI = 3'h2,
    ABM_OPB_IMM_LO = 3'h3,
    ABM_OPB_AUX    = 3'h4
  } abm_opb_t;

  typedef struct packed {
    abm_op_t     op;
    abm_opb_t    opbSel;
    logic        srcAcc;
    logic        secAcc;
    logic        dstAcc;
    logic        noDest;
    logic        altSel;
    logic [1:0]  auxSel;
    logic [15:0] imm;
  } abm_cmd_t;

  typedef struct packed {
    logic negativeFlag;
    logic zeroFlag;
    logic logicalOverflowFlag;
    logic mathOverflowFlag;
  } abm_psw_t;

  typedef struct packed {
    logic notMinusOneFlag;
    logic minusOneFlag;
    logic evenParity;
    logic oddParity;
  } abm_bmu_flags_t;

endpackage

/* rtl/abm_bmu_unit.sv */
/*
  Combinational shifter, exponent, normalize and field unit.
  Assumes the caller registers the result and flags.
*/
`timescale 1ns/1ps
`include "abm_map.svh"
module abm_bmu_unit #(
  parameter int ACC_W = `ABM_ACC_W
) (
  input  wire abm_pkg::abm_op_t       op,
  input  wire logic [ACC_W-1:0]       srcVal,
  input  wire logic [ACC_W-1:0]       dstVal,
  input  wire logic [15:0]            opnd,
  output logic      [ACC_W-1:0]       result,
  output logic                        ovf36,
  output logic                        illegal
);
  import abm_pkg::*;
  localparam int SW = $clog2(ACC_W + 1);

  logic [SW-1:0]        amt;
  logic [SW-1:0]        nAmt;
  logic [7:0]           fldW;
  logic [7:0]           fldOff;
  logic [ACC_W-1:0]     mask;
  logic [ACC_W-1:0]     slc;
  logic [ACC_W-1:0]     fieldMask;
  logic [ACC_W-1:0]     shl;
  logic [SW-1:0]        lead;
  logic                 run;
  logic signed [15:0]   expo;

  always_comb begin
    amt = (opnd > 16'(ACC_W)) ? SW'(ACC_W) : SW'(opnd);
    nAmt = ((-opnd) > 16'(ACC_W)) ? SW'(ACC_W) : SW'(-opnd);
    fldW = opnd[`ABM_FLD_W_LSB +: `ABM_BYTE_W];
    fldOff = opnd[0 +: `ABM_BYTE_W];
    illegal = (9'(fldW) + 9'(fldOff)) > 9'(ACC_W);
    mask = (fldW >= 8'(ACC_W)) ? '1 : ~({ACC_W{1'b1}} << fldW);
    slc = (srcVal >> fldOff) & mask;
    fieldMask = mask << fldOff;
    shl = srcVal << amt;
    lead = '0;
    run = 1'b1;
    for (int i = ACC_W - 2; i >= 0; i--) begin
      if (run && (srcVal[i] == srcVal[ACC_W-1])) begin
        lead = lead + 1'b1;
      end else begin
        run = 1'b0;
      end
    end
    expo = 16'(lead) - 16'(`ABM_GUARD_W);
    ovf36 = 1'b0;
    case (op)
      ABM_OP_ASR: result = ACC_W'($signed(srcVal) >>> amt);
      ABM_OP_LSR: result = ACC_W'(srcVal[`ABM_LOW_W-1:0] >> amt);
      ABM_OP_ASL: begin
        result = shl;
        ovf36 = ($signed(shl) >>> amt) != $signed(srcVal);
      end
      ABM_OP_EXP: result = ACC_W'($signed(expo));
      ABM_OP_NORM: begin
        if (opnd[15]) begin
          result = ACC_W'($signed(srcVal) >>> nAmt);
        end else begin
          result = shl;
          ovf36 = ($signed(shl) >>> amt) != $signed(srcVal);
        end
      end
      ABM_OP_EXTS: result = (|(slc & ~(mask >> 1))) ? (slc | ~mask) : slc;
      ABM_OP_EXTZ: result = slc;
      ABM_OP_INS: result = (dstVal & ~fieldMask) | ((srcVal << fldOff) & fieldMask);
      default: result = srcVal;
    endcase
  end
endmodule

/* rtl/abm_datapath.sv */
/*
  Accumulator ALU and bit manipulation datapath with its register state.
  Assumes the decoder drives one command per accept and holds the product.
*/
`timescale 1ns/1ps
`include "abm_map.svh"
module abm_datapath #(
  parameter int ACC_W = `ABM_ACC_W
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   cmdValid,
  input  wire abm_pkg::abm_cmd_t      cmd,
  input  wire logic [31:0]            prodVal,
  input  wire logic                   auxWrEn,
  input  wire logic [1:0]             auxWrSel,
  input  wire logic [15:0]            auxWrData,
  input  wire logic                   flagWrEn,
  input  wire abm_pkg::abm_bmu_flags_t flagWrData,
  output logic                        cmdReady,
  output logic                        done,
  output logic [ACC_W-1:0]            acc0,
  output logic [ACC_W-1:0]            acc1,
  output logic [ACC_W-1:0]            altAcc0,
  output logic [ACC_W-1:0]            altAcc1,
  output abm_pkg::abm_psw_t           pswFlags,
  output abm_pkg::abm_bmu_flags_t     bmuFlags
);
  import abm_pkg::*;

  if (ACC_W != `ABM_ACC_W) begin : g_chk
    $error("accumulator width must be 36");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } abm_state_t;

  function automatic logic abm_two_cyc(input abm_cmd_t c);
    logic r;
    r = 1'b0;
    case (c.op)
      ABM_OP_ADD, ABM_OP_SUB, ABM_OP_AND, ABM_OP_OR, ABM_OP_XOR:
        r = (c.opbSel == ABM_OPB_IMM_HI) || (c.opbSel == ABM_OPB_IMM_LO);
      ABM_OP_ASR, ABM_OP_LSR, ABM_OP_ASL, ABM_OP_EXTS, ABM_OP_EXTZ:
        r = (c.opbSel != ABM_OPB_AUX);
      ABM_OP_INS: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // reset release
  logic                rstMeta_r;
  logic                rstSync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // state
  abm_state_t          state_r;
  logic [1:0]          waitCnt_r;
  abm_cmd_t            cmd_r;
  logic                cmdReady_r;
  logic                done_r;
  logic [ACC_W-1:0]    acc_r [2];
  logic [ACC_W-1:0]    alt_r [`ABM_ALT_N];
  logic [15:0]         aux_r [`ABM_AUX_N];
  abm_psw_t            psw_r;
  abm_bmu_flags_t      bflg_r;
  logic [ACC_W-1:0]    lastRes_r;
  logic                lastBmu_r;

  // datapath nets
  logic                accept;
  logic                twoCyc;
  logic                commitEn;
  abm_cmd_t            cur;
  logic [ACC_W-1:0]    srcVal;
  logic [ACC_W-1:0]    secVal;
  logic [ACC_W-1:0]    dstVal;
  logic [ACC_W-1:0]    opB;
  logic [15:0]         opnd;
  logic [ACC_W:0]      sum;
  logic [ACC_W-1:0]    aluRes;
  logic [ACC_W-1:0]    bmuRes;
  logic [ACC_W-1:0]    res;
  logic                bmuOvf;
  logic                bmuIll;
  logic                isAlu;
  logic                isField;
  logic                aluOvf;
  logic                writeDst;

  assign accept = cmdReady_r && cmdValid && (state_r == ST_IDLE);
  assign twoCyc = abm_two_cyc(cmd);
  assign cur = (state_r == ST_WAIT) ? cmd_r : cmd;
  assign commitEn = (accept && !twoCyc) || ((state_r == ST_WAIT) && (waitCnt_r == 2'd1));
  assign isAlu = (cur.op <= ABM_OP_XOR);
  assign isField = (cur.op == ABM_OP_EXTS) || (cur.op == ABM_OP_EXTZ) || (cur.op == ABM_OP_INS);

  // operand selection
  always_comb begin
    srcVal = acc_r[cur.srcAcc];
    secVal = acc_r[cur.secAcc];
    dstVal = acc_r[cur.dstAcc];
    case (cur.opbSel)
      ABM_OPB_ACC: begin
        opB = secVal;
        opnd = secVal[`ABM_HALF_LO +: `ABM_IMM_W];
      end
      ABM_OPB_PROD: begin
        opB = {{`ABM_GUARD_W{prodVal[31]}}, prodVal};
        opnd = prodVal[15:0];
      end
      ABM_OPB_IMM_HI: begin
        opB = {{`ABM_GUARD_W{cur.imm[15]}}, cur.imm,
               (cur.op == ABM_OP_AND) ? 16'hFFFF : 16'h0000};
        opnd = cur.imm;
      end
      ABM_OPB_IMM_LO: begin
        opB = {(cur.op == ABM_OP_AND) ? 20'hF_FFFF : 20'h0_0000, cur.imm};
        opnd = cur.imm;
      end
      ABM_OPB_AUX: begin
        opB = ACC_W'($signed(aux_r[cur.auxSel]));
        opnd = aux_r[cur.auxSel];
      end
      default: begin
        opB = secVal;
        opnd = cur.imm;
      end
    endcase
    if (cur.op == ABM_OP_NORM) begin
      opnd = aux_r[cur.auxSel];
    end
  end

  // arithmetic and logic
  always_comb begin
    sum = '0;
    case (cur.op)
      ABM_OP_ADD: sum = {srcVal[ACC_W-1], srcVal} + {opB[ACC_W-1], opB};
      ABM_OP_SUB: sum = {srcVal[ACC_W-1], srcVal} - {opB[ACC_W-1], opB};
      ABM_OP_AND: sum = {1'b0, srcVal & opB};
      ABM_OP_OR:  sum = {1'b0, srcVal | opB};
      ABM_OP_XOR: sum = {1'b0, srcVal ^ opB};
      default:    sum = '0;
    endcase
    aluRes = sum[ACC_W-1:0];
    aluOvf = ((cur.op == ABM_OP_ADD) || (cur.op == ABM_OP_SUB)) && (sum[ACC_W] != sum[ACC_W-1]);
  end

  abm_bmu_unit #(
    .ACC_W (ACC_W)
  ) u_bmu (
    .op      (cur.op),
    .srcVal  (srcVal),
    .dstVal  (dstVal),
    .opnd    (opnd),
    .result  (bmuRes),
    .ovf36   (bmuOvf),
    .illegal (bmuIll)
  );

  assign res = isAlu ? aluRes : ((cur.op == ABM_OP_SHUF) ? alt_r[cur.altSel] : bmuRes);
  assign writeDst = !(cur.noDest && ((cur.op == ABM_OP_SUB) || (cur.op == ABM_OP_AND)));

  // sequencing
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r <= ST_IDLE;
      waitCnt_r <= 2'd0;
      cmd_r <= '0;
      cmdReady_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= commitEn;
      case (state_r)
        ST_IDLE: begin
          cmdReady_r <= 1'b1;
          if (accept && twoCyc) begin
            cmd_r <= cmd;
            waitCnt_r <= 2'(`ABM_LONG_CYC - 1);
            state_r <= ST_WAIT;
            cmdReady_r <= 1'b0;
          end
        end
        ST_WAIT: begin
          waitCnt_r <= waitCnt_r - 2'd1;
          if (waitCnt_r == 2'd1) begin
            state_r <= ST_IDLE;
            cmdReady_r <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cmdReady_r <= 1'b0;
        end
      endcase
    end
  end

  // working accumulators
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      acc_r[0] <= `ABM_ACC_RST;
      acc_r[1] <= `ABM_ACC_RST;
    end else if (commitEn && writeDst) begin
      acc_r[cur.dstAcc] <= res;
    end
  end

  // alternate accumulators
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      alt_r[0] <= `ABM_ACC_RST;
      alt_r[1] <= `ABM_ACC_RST;
    end else if (commitEn && (cur.op == ABM_OP_SHUF)) begin
      alt_r[cur.altSel] <= srcVal;
    end
  end

  // auxiliary registers
  for (genvar g = 0; g < `ABM_AUX_N; g++) begin : g_aux
    always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        aux_r[g] <= `ABM_AUX_RST;
      end else if (auxWrEn && (auxWrSel == 2'(g))) begin
        aux_r[g] <= auxWrData;
      end
    end
  end

  // condition flags
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      psw_r <= '0;
    end else if (commitEn) begin
      psw_r.negativeFlag <= res[ACC_W-1];
      psw_r.zeroFlag <= (res == '0);
      psw_r.logicalOverflowFlag <= aluOvf || bmuOvf || (isField && bmuIll);
      psw_r.mathOverflowFlag <= !((&res[ACC_W-1:`ABM_MOV_LO]) ||
                                  (~|res[ACC_W-1:`ABM_MOV_LO]));
    end
  end

  // hardware update wins over a software write in the same cycle
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      bflg_r <= '0;
    end else if (commitEn && !isAlu) begin
      bflg_r.oddParity <= ^res;
      bflg_r.evenParity <= ~^res;
      bflg_r.minusOneFlag <= &res;
      bflg_r.notMinusOneFlag <= ~&res;
    end else if (flagWrEn) begin
      bflg_r <= flagWrData;
    end
  end

  // last committed result
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lastRes_r <= `ABM_ACC_RST;
      lastBmu_r <= 1'b0;
    end else if (commitEn) begin
      lastRes_r <= res;
      lastBmu_r <= !isAlu;
    end
  end

  assign cmdReady = cmdReady_r;
  assign done = done_r;
  assign acc0 = acc_r[0];
  assign acc1 = acc_r[1];
  assign altAcc0 = alt_r[0];
  assign altAcc1 = alt_r[1];
  assign pswFlags = psw_r;
  assign bmuFlags = bflg_r;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSync_n);

  sequence s_longAccept;
    accept && twoCyc;
  endsequence

  sequence s_holdThenDone;
    (!cmdReady_r && !done_r) ##1 (done_r && cmdReady_r);
  endsequence

  property p_longTiming;
    s_longAccept |=> s_holdThenDone;
  endproperty
  a_longTiming: assert property (p_longTiming)
    else $error("two-cycle command not finished in two cycles");

  property p_shortTiming;
    (accept && !twoCyc) |=> (done_r && cmdReady_r);
  endproperty
  a_shortTiming: assert property (p_shortTiming)
    else $error("one-cycle command not finished in one cycle");

  property p_compareKeeps;
    (commitEn && cur.noDest && (cur.op == ABM_OP_SUB)) |=> $stable(acc0) && $stable(acc1);
  endproperty
  a_compareKeeps: assert property (p_compareKeeps)
    else $error("compare wrote an accumulator");

  property p_mathOvf;
    done_r |-> (psw_r.mathOverflowFlag ==
               ((lastRes_r[35:31] != 5'h00) && (lastRes_r[35:31] != 5'h1F)));
  endproperty
  a_mathOvf: assert property (p_mathOvf)
    else $error("math overflow flag wrong");

  property p_zeroNeg;
    done_r |-> (psw_r.zeroFlag == (lastRes_r == '0)) && (psw_r.negativeFlag == lastRes_r[35]);
  endproperty
  a_zeroNeg: assert property (p_zeroNeg)
    else $error("zero or negative flag wrong");

  property p_minusOne;
    (done_r && lastBmu_r) |-> (bmuFlags.minusOneFlag == (&lastRes_r)) &&
                              (bmuFlags.notMinusOneFlag != bmuFlags.minusOneFlag);
  endproperty
  a_minusOne: assert property (p_minusOne)
    else $error("minus-one flags wrong");

  property p_shuffle;
    (commitEn && (cur.op == ABM_OP_SHUF) && !cur.altSel && !cur.srcAcc)
      |=> (altAcc0 == $past(acc0));
  endproperty
  a_shuffle: assert property (p_shuffle)
    else $error("alternate accumulator not loaded from source");

  property p_illegalField;
    (commitEn && isField && bmuIll) |=> psw_r.logicalOverflowFlag;
  endproperty
  a_illegalField: assert property (p_illegalField)
    else $error("illegal field did not raise logical overflow");

  property p_prodExtend;
    (commitEn && (cur.opbSel == ABM_OPB_PROD)) |-> (opB[35:32] == {4{prodVal[31]}});
  endproperty
  a_prodExtend: assert property (p_prodExtend)
    else $error("product not sign-extended");

endmodule

/* tb/abm_datapath_test.sv */
/*
  Self-checking bench of the accumulator ALU and bit manipulation datapath.
  Assumes abm_pkg and abm_map.svh are compiled ahead of it.
*/
`timescale 1ns/1ps
`include "abm_map.svh"
module abm_datapath_test;
  import abm_pkg::*;
  localparam int W = `ABM_ACC_W;
  logic           clk;
  logic           rst_n;
  logic           cmdValid;
  abm_cmd_t       cmd;
  logic [31:0]    prodVal;
  logic           auxWrEn;
  logic [1:0]     auxWrSel;
  logic [15:0]    auxWrData;
  logic           flagWrEn;
  abm_bmu_flags_t flagWrData;
  logic           cmdReady;
  logic           done;
  logic [W-1:0]   acc0;
  logic [W-1:0]   acc1;
  logic [W-1:0]   altAcc0;
  logic [W-1:0]   altAcc1;
  abm_psw_t       pswFlags;
  abm_bmu_flags_t bmuFlags;
  int             n_fail;
  int             n_tests;
  int             cycles;
  logic [W-1:0]   mAcc [2];
  logic [W-1:0]   mAlt [2];
  logic [15:0]    mAux [4];
  logic [W-1:0]   eRes;
  logic           eLlv;
  bit             eLlvOn;
  bit             eTwo;
  logic [3:0]     mBf;

  abm_datapath dut (
    .clk        (clk),
    .rst_n      (rst_n),
    .cmdValid   (cmdValid),
    .cmd        (cmd),
    .prodVal    (prodVal),
    .auxWrEn    (auxWrEn),
    .auxWrSel   (auxWrSel),
    .auxWrData  (auxWrData),
    .flagWrEn   (flagWrEn),
    .flagWrData (flagWrData),
    .cmdReady   (cmdReady),
    .done       (done),
    .acc0       (acc0),
    .acc1       (acc1),
    .altAcc0    (altAcc0),
    .altAcc1    (altAcc1),
    .pswFlags   (pswFlags),
    .bmuFlags   (bmuFlags)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask

  // reference behaviour of one command, updates the model state
  function automatic void predict(input abm_cmd_t c, input logic [31:0] pv);
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [W-1:0] m;
    logic [15:0]  f;
    int           n;
    int           w;
    int           o;
    int           k;
    bit           wr;
    a = mAcc[c.srcAcc];
    f = (c.opbSel == ABM_OPB_AUX) ? mAux[c.auxSel] : c.imm;
    case (c.opbSel)
      ABM_OPB_PROD:   b = {{4{pv[31]}}, pv};
      ABM_OPB_IMM_HI: b = {{4{c.imm[15]}}, c.imm, {16{c.op == ABM_OP_AND}}};
      ABM_OPB_IMM_LO: b = {{20{c.op == ABM_OP_AND}}, c.imm};
      default:        b = mAcc[c.secAcc];
    endcase
    n = (c.opbSel == ABM_OPB_ACC) ? int'(b[31:16]) : int'(f);
    n = (n > 36) ? 36 : n;
    w = f[15:8];
    o = f[7:0];
    m = (w >= 36) ? '1 : (36'h1 << w) - 36'h1;
    eLlv = 1'b0;
    eLlvOn = c.op <= ABM_OP_XOR || c.op >= ABM_OP_EXTS && c.op <= ABM_OP_INS;
    eTwo = (c.op <= ABM_OP_XOR) ? c.opbSel inside {ABM_OPB_IMM_HI, ABM_OPB_IMM_LO} :
           (c.op == ABM_OP_INS) || (c.op != ABM_OP_EXP && c.op != ABM_OP_NORM &&
           c.op != ABM_OP_SHUF && c.opbSel != ABM_OPB_AUX);
    wr = !(c.noDest && c.op inside {ABM_OP_SUB, ABM_OP_AND});
    k = 0;
    case (c.op)
      ABM_OP_ADD:  eRes = a + b;
      ABM_OP_SUB:  eRes = a - b;
      ABM_OP_AND:  eRes = a & b;
      ABM_OP_OR:   eRes = a | b;
      ABM_OP_XOR:  eRes = a ^ b;
      ABM_OP_ASR:  eRes = $signed(a) >>> n;
      ABM_OP_LSR:  eRes = {4'h0, a[31:0] >> n};
      ABM_OP_ASL:  eRes = a << n;
      ABM_OP_EXP: begin
        while (k < 35 && a[34-k] == a[35]) k++;
        eRes = 36'(k - 4);
      end
      ABM_OP_NORM: begin
        k = $signed(f);
        if (k >= 0) eRes = a << k;
        else eRes = $signed(a) >>> (-k);
      end
      ABM_OP_INS:  eRes = (mAcc[c.dstAcc] & ~(m << o)) | ((a & m) << o);
      ABM_OP_SHUF: begin
        eRes = mAlt[c.altSel];
        mAlt[c.altSel] = a;
      end
      default: begin
        eRes = (a >> o) & m;
        if (c.op == ABM_OP_EXTS && w > 0 && eRes[w-1]) eRes = eRes | ~m;
      end
    endcase
    if (c.op == ABM_OP_ADD) eLlv = a[35] == b[35] && eRes[35] != a[35];
    if (c.op == ABM_OP_SUB) eLlv = a[35] != b[35] && eRes[35] != a[35];
    if (c.op >= ABM_OP_EXTS && c.op <= ABM_OP_INS) eLlv = w + o > 36;
    if (wr) mAcc[c.dstAcc] = eRes;
    if (c.op > ABM_OP_XOR) mBf = {~&eRes, &eRes, ~^eRes, ^eRes};
  endfunction

  task automatic doCmd(input abm_cmd_t c, input logic [31:0] pv);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (cmdReady !== 1'b1 && k < 20);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd      <= c;
    prodVal  <= pv;
    @(posedge clk);
    cmdValid <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 6);
    check("latency", k, eTwo ? 2 : 1);
  endtask

  task automatic auxWrite(input logic [1:0] sel, input logic [15:0] val);
    @(posedge clk);
    auxWrEn   <= 1'b1;
    auxWrSel  <= sel;
    auxWrData <= val;
    @(posedge clk);
    auxWrEn <= 1'b0;
    mAux[sel] = val;
  endtask

  task automatic run(input abm_cmd_t c, input logic [31:0] pv);
    predict(c, pv);
    doCmd(c, pv);
    check("acc0", acc0, mAcc[0]);
    check("acc1", acc1, mAcc[1]);
    check("altAcc0", altAcc0, mAlt[0]);
    check("altAcc1", altAcc1, mAlt[1]);
    check("negative", pswFlags.negativeFlag, eRes[35]);
    check("zero", pswFlags.zeroFlag, eRes == '0);
    check("mathOvf", pswFlags.mathOverflowFlag, ^{&eRes[35:31], |eRes[35:31]});
    if (eLlvOn) check("logicOvf", pswFlags.logicalOverflowFlag, eLlv);
    check("bmuHwFlags", bmuFlags, mBf);
  endtask

  function automatic abm_cmd_t mk(abm_op_t op, abm_opb_t ob, bit s, bit t, bit d, bit nd,
                                  bit al, logic [1:0] ax, logic [15:0] im);
    mk = '{op, ob, s, t, d, nd, al, ax, im};
  endfunction

  task automatic doReset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    check("readyInReset", cmdReady, 1'b0);
    rst_n <= 1'b1;
    foreach (mAcc[i]) mAcc[i] = `ABM_ACC_RST;
    foreach (mAlt[i]) mAlt[i] = `ABM_ACC_RST;
    foreach (mAux[i]) mAux[i] = `ABM_AUX_RST;
    mBf = '0;
  endtask

  initial begin
    abm_cmd_t    c;
    int          w;
    int          s;
    logic [15:0] f;
    logic [15:0] v;
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmd = '0;
    prodVal = '0;
    auxWrEn = 1'b0;
    auxWrSel = '0;
    auxWrData = '0;
    flagWrEn = 1'b0;
    flagWrData = '0;
    void'($urandom(32'hBA15));
    doReset();
    run(mk(ABM_OP_ADD, ABM_OPB_IMM_HI, 0, 0, 0, 0, 0, 0, 16'h7FFF), 32'h0);
    run(mk(ABM_OP_OR, ABM_OPB_IMM_LO, 0, 0, 0, 0, 0, 0, 16'hFFFF), 32'h0);
    auxWrite(2'h1, 16'h0004);
    run(mk(ABM_OP_ASL, ABM_OPB_AUX, 0, 0, 1, 0, 0, 1, 16'h0), 32'h0);
    run(mk(ABM_OP_ADD, ABM_OPB_ACC, 1, 1, 0, 0, 0, 0, 16'h0), 32'h0);
    run(mk(ABM_OP_SUB, ABM_OPB_ACC, 0, 1, 0, 1, 0, 0, 16'h0), 32'h0);
    run(mk(ABM_OP_AND, ABM_OPB_IMM_HI, 1, 0, 0, 1, 0, 0, 16'h8000), 32'h0);
    run(mk(ABM_OP_ADD, ABM_OPB_PROD, 0, 0, 1, 0, 0, 0, 16'h0), 32'h8000_0001);
    run(mk(ABM_OP_SHUF, ABM_OPB_AUX, 1, 0, 0, 0, 1, 0, 16'h0), 32'h0);
    run(mk(ABM_OP_ASR, ABM_OPB_IMM_LO, 0, 0, 1, 0, 0, 0, 16'h0024), 32'h0);
    run(mk(ABM_OP_EXTS, ABM_OPB_IMM_LO, 1, 0, 0, 0, 0, 0, 16'h081C), 32'h0);
    for (int i = 0; i < 300; i++) begin
      c = abm_cmd_t'($urandom);
      c.op = abm_op_t'($urandom_range(0, 13));
      w = $urandom_range(1, 36);
      f = {8'(w), 8'($urandom_range(0, 36 - w))};
      s = $urandom_range(0, 2);
      v = 16'($urandom_range(0, 40));
      if (c.op <= ABM_OP_XOR) c.opbSel = abm_opb_t'($urandom_range(0, 3));
      if (c.op inside {ABM_OP_ASR, ABM_OP_LSR, ABM_OP_ASL}) c.opbSel = abm_opb_t'(s ? s + 2 : 0);
      if (c.op >= ABM_OP_EXP) c.opbSel = ABM_OPB_AUX;
      if (c.op >= ABM_OP_EXTS && c.op <= ABM_OP_INS) begin
        c.opbSel = s ? ABM_OPB_AUX : ABM_OPB_IMM_LO;
        c.imm = f;
        v = f;
      end
      if (c.op == ABM_OP_NORM) v = v - 16'd8;
      auxWrite(c.auxSel, v);
      run(c, $urandom);
    end
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      @(posedge clk);
      flagWrEn   <= 1'b1;
      flagWrData <= v[3:0];
      @(posedge clk);
      flagWrEn <= 1'b0;
      @(negedge clk);
      check("bmuFlags", bmuFlags, v[3:0]);
      mBf = v[3:0];
    end
    auxWrite(2'h3, 16'h1E07);
    c = mk(ABM_OP_EXTZ, ABM_OPB_AUX, 0, 0, 0, 0, 0, 3, 16'h0);
    predict(c, 32'h0);
    doCmd(c, 32'h0);
    check("illegalField", pswFlags.logicalOverflowFlag, 1'b1);
    c = mk(ABM_OP_INS, ABM_OPB_IMM_LO, 0, 0, 1, 0, 0, 0, 16'h2410);
    predict(c, 32'h0);
    doCmd(c, 32'h0);
    check("illegalIns", pswFlags.logicalOverflowFlag, 1'b1);
    doReset();
    run(mk(ABM_OP_EXP, ABM_OPB_AUX, 0, 0, 1, 0, 0, 0, 16'h0), 32'h0);
    run(mk(ABM_OP_SHUF, ABM_OPB_AUX, 1, 0, 0, 0, 0, 0, 16'h0), 32'h0);
    end_sim();
  end
endmodule
